//--- hw/srs_regs.svh
// constants for the recirculating static shift register store
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

// bits in one segment; four segments make the full store
`define SRS_SEG_BITS 128
`define SRS_NUM_SEG 4

`endif

//--- hw/srs_pkg.sv
// types for the recirculating static shift register store
package srs_pkg;

   // how the four segments are chained into registers
   typedef enum logic [1:0]
   {
      SRS_QUAD = 2'h0,
      SRS_DUAL = 2'h1,
      SRS_SINGLE = 2'h3
   } srs_cfg_t;

   // pin group driven by the external controller
   typedef struct packed
   {
      logic shift_clk;
      logic loop_back_select;
      logic [3:0] data_in;
   } srs_pins_t;

endpackage

//--- hw/srs_shift_store.sv
// recirculating static shift register store, four segments of master/slave stages
//
// Functional notes
// - store works as four 128-bit, two 256-bit or one 512-bit register
// - each register has one serial input, bit taken on clock falling edge
// - one loop-back select governs all registers: input pin or own output
// - loop-back select low: shift in the external data input bit
// - loop-back select high: output bit is written back into register input
// - clock held low keeps every stored bit; shifting resumes on restart
// - master captures while clock high, static slave takes it while low
`timescale 1ns/1ps
`include "srs_regs.svh"

module srs_shift_store
   import srs_pkg::*;
#(
   parameter srs_cfg_t CFG = SRS_QUAD,
   parameter int SEG_BITS = `SRS_SEG_BITS
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // controller pins
   input wire srs_pins_t pins,
   // serial outputs, one per register, unused ones read zero
   output logic [3:0] data_out
);

   localparam int NSEG = `SRS_NUM_SEG;
   localparam int TOT = NSEG * SEG_BITS;

   // ==========================================
   // pin synchronisers
   // ==========================================
   srs_pins_t pins_s1_reg;
   srs_pins_t pins_s2_reg;
   logic clk_d_reg;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_s1_reg <= '0;
         pins_s2_reg <= '0;
         clk_d_reg <= 1'b0;
      end
      else
      begin
         pins_s1_reg <= pins;
         pins_s2_reg <= pins_s1_reg;
         clk_d_reg <= pins_s2_reg.shift_clk;
      end
   end

   logic clk_s;
   logic loop_s;
   logic [3:0] din_s;
   logic fall;

   assign clk_s = pins_s2_reg.shift_clk;
   assign loop_s = pins_s2_reg.loop_back_select;
   assign din_s = pins_s2_reg.data_in;
   // data and clock share the same synchroniser depth, so they stay aligned
   assign fall = clk_d_reg & ~clk_s;

   // ==========================================
   // register chaining
   // ==========================================
   logic [TOT-1:0] master_reg;
   logic [TOT-1:0] slave_reg;
   logic [TOT-1:0] master_next;
   logic [NSEG-1:0] seg_end;
   logic [3:0] reg_out;
   logic [3:0] src_vec;
   logic [NSEG-1:0] seg_in;

   always_comb
   begin
      for (int k = 0; k < NSEG; k++)
      begin
         seg_end[k] = slave_reg[k*SEG_BITS + SEG_BITS - 1];
      end
   end

   always_comb
   begin
      case (CFG)
         SRS_QUAD:
            reg_out = seg_end;
         SRS_DUAL:
            reg_out = {2'h0, seg_end[3], seg_end[1]};
         SRS_SINGLE:
            reg_out = {3'h0, seg_end[3]};
         default:
            reg_out = seg_end;
      endcase
   end

   assign src_vec = loop_s ? reg_out : din_s;

   // segment inputs chain segments into registers
   always_comb
   begin
      case (CFG)
         SRS_QUAD:
            seg_in = src_vec;
         SRS_DUAL:
            seg_in = {seg_end[2], src_vec[1], seg_end[0], src_vec[0]};
         SRS_SINGLE:
            seg_in = {seg_end[2], seg_end[1], seg_end[0], src_vec[0]};
         default:
            seg_in = src_vec;
      endcase
   end

   genvar g;
   generate
      for (g = 0; g < NSEG; g++)
      begin : g_seg
         assign master_next[g*SEG_BITS +: SEG_BITS] =
            {slave_reg[g*SEG_BITS +: SEG_BITS-1], seg_in[g]};
      end
   endgenerate

   // ==========================================
   // master and slave stages
   // ==========================================
   // master follows while high
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         master_reg <= '0;
      else if (clk_s)
         master_reg <= master_next;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         slave_reg <= '0;
      else if (fall)
         slave_reg <= master_reg;
   end

   // output is the last slave stage
   assign data_out = reg_out;

   // ==========================================
   // assertions
   // ==========================================
   sequence s_high_then_fall;
      clk_s ##1 !clk_s;
   endsequence

   sequence s_held_low;
      !clk_d_reg && !clk_s;
   endsequence

   property p_cfg_chain;
      @(posedge sys_clk) disable iff (!rst_n)
      (CFG != SRS_QUAD && fall) |=> slave_reg[SEG_BITS] == $past(slave_reg[SEG_BITS-1]);
   endproperty
   a_cfg_chain: assert property (p_cfg_chain) else $error("segments not chained");

   property p_unused_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      (CFG == SRS_SINGLE) |-> data_out[3:1] == 3'h0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused output not zero");

   property p_dual_unused;
      @(posedge sys_clk) disable iff (!rst_n)
      (CFG == SRS_DUAL) |-> data_out[3:2] == 2'h0;
   endproperty
   a_dual_unused: assert property (p_dual_unused) else $error("unused pair not zero");

   property p_fall_take;
      @(posedge sys_clk) disable iff (!rst_n)
      fall |=> slave_reg[0] == $past(src_vec[0], 2);
   endproperty
   a_fall_take: assert property (p_fall_take) else $error("input bit not taken");

   property p_shared_select;
      @(posedge sys_clk) disable iff (!rst_n)
      (CFG == SRS_QUAD && fall) |=> slave_reg[3*SEG_BITS] == $past(src_vec[3], 2);
   endproperty
   a_shared_select: assert property (p_shared_select) else $error("select not shared");

   property p_load_ext;
      @(posedge sys_clk) disable iff (!rst_n)
      (fall && !$past(loop_s)) |=> slave_reg[0] == $past(din_s[0], 2);
   endproperty
   a_load_ext: assert property (p_load_ext) else $error("external bit lost");

   property p_recirc;
      @(posedge sys_clk) disable iff (!rst_n)
      (fall && $past(loop_s)) |=> slave_reg[0] == $past(reg_out[0], 2);
   endproperty
   a_recirc: assert property (p_recirc) else $error("output not recirculated");

   property p_hold_low;
      @(posedge sys_clk) disable iff (!rst_n)
      s_held_low |=> $stable(slave_reg) && $stable(master_reg);
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("data moved while clock low");

   property p_master_slave;
      @(posedge sys_clk) disable iff (!rst_n)
      s_high_then_fall |=> slave_reg == $past(master_reg);
   endproperty
   a_master_slave: assert property (p_master_slave) else $error("slave missed master");

   property p_out_delay;
      @(posedge sys_clk) disable iff (!rst_n)
      (CFG == SRS_SINGLE && fall) |=>
         slave_reg[TOT-1:1] == $past(slave_reg[TOT-2:0]) && data_out[0] == slave_reg[TOT-1];
   endproperty
   a_out_delay: assert property (p_out_delay) else $error("output delay wrong");

endmodule

//--- sim/srs_ctl_model.sv
// external controller model driving the shift store pins
`timescale 1ns/1ps

module srs_ctl_model
   import srs_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // pins to the store
   output srs_pins_t pins
);
   // clock rests low between pulses, data never floats
   initial
   begin
      pins = '0;
   end

   task automatic pulse(input logic [3:0] d, input logic sel);
      @(posedge sys_clk);
      pins.data_in <= d;
      pins.loop_back_select <= sel;
      repeat (3) @(posedge sys_clk);
      pins.shift_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      pins.shift_clk <= 1'b0;
      // data held well past the fall, two-flop sync
      repeat (7) @(posedge sys_clk);
   endtask

   // data and select may move while the clock rests low
   task automatic idle(input logic [3:0] d, input logic sel);
      @(posedge sys_clk);
      pins.data_in <= d;
      pins.loop_back_select <= sel;
   endtask
endmodule

//--- sim/testbench.sv
// testbench for the shift store in all three build shapes
`timescale 1ns/1ps

module testbench
   import srs_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   srs_pins_t pins;
   logic [3:0] q [3];
   logic [15:0] m [3][4] = '{default: '0};
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam srs_cfg_t CFGS [3] = '{SRS_QUAD, SRS_DUAL, SRS_SINGLE};
   // short 4-bit segments: register lengths 4, 8, 16
   localparam int LEN [3] = '{4, 8, 16};
   localparam int NREG [3] = '{4, 2, 1};

   always #5 sys_clk = ~sys_clk;

   srs_ctl_model ctl (.sys_clk(sys_clk), .pins(pins));

   for (genvar c = 0; c < 3; c++)
   begin : g_cfg
      srs_shift_store #(.CFG(CFGS[c]), .SEG_BITS(4)) DUT (
         .sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .data_out(q[c]));
   end

   task check(string what, logic [3:0] seen, logic [3:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [3:0] exp_out(int c);
      logic [3:0] e;
      e = '0;
      for (int r = 0; r < NREG[c]; r++) e[r] = m[c][r][LEN[c]-1];
      return e;
   endfunction

   task automatic step(input logic [3:0] d, input logic sel);
      logic b;
      ctl.pulse(d, sel);
      #1;
      for (int c = 0; c < 3; c++)
      begin
         for (int r = 0; r < NREG[c]; r++)
         begin
            b = sel ? m[c][r][LEN[c]-1] : d[r];
            m[c][r] = {m[c][r][14:0], b};
         end
         check("data_out", q[c], exp_out(c));
      end
   endtask

   task automatic load_walk();
      for (int i = 0; i < 20; i++) step(4'(i * 7 + 3), 1'b0);
   endtask

   task automatic recirc();
      for (int i = 0; i < 20; i++) step(~4'(i), 1'b1);
   endtask

   // inputs wiggle while the clock is low, so a stray shift would show
   task automatic hold_low();
      for (int i = 0; i < 50; i++) ctl.idle(4'(i), 1'(i % 2));
      repeat (4) @(posedge sys_clk);
      #1;
      for (int c = 0; c < 3; c++) check("held", q[c], exp_out(c));
   endtask

   task automatic mixed();
      for (int i = 0; i < 12; i++) step(4'(i * 5), 1'(i % 3 == 0));
   endtask

   task close_out();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      load_walk();
      recirc();
      hold_low();
      mixed();
      close_out();
   end

   // about 850 cycles expected
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_mismatch++;
         close_out();
      end
   end
endmodule
